//--- power_mode_and_base_clock_control.sv
// Power-mode sequencer, supply reset, host clock gate and base timing.
// Assumes mclk is the crystal oscillator and all pins are synchronous.
// Operation
// - base clock is crystal divided by 16; the bit-check timer uses it and base_tick brings it out
// - polling, bit-check and transmit bit rate are timed from base clock
// - bit-check period is base period times limit times 8, 4, 2 or 1
// - leave OFF for IDLE on high wake pin or low push-button pin
// - on wake raise interrupt and set status bit of the waking pin
// - OFF command returns to OFF; host first releases both wake pins
// - in OFF no register programming is accepted
// - all-zero mode bits mean IDLE with the RF section off
// - mode codes 0,1,2,3,5,7 are used; 4 and 6 are unused
// - switch-on reset clears logic, loads defaults, sets reset flag
// - reset flag clears on status read once supply and oscillator good
// - host clock runs only after supply good and oscillator started
// - host clock is crystal divided by three, two cycles high and one low
// - supply-good signal follows the supply monitor threshold
// - supply loss with wake pins released falls back to OFF
`timescale 1ns/1ps
`default_nettype none
module power_mode_and_base_clock_control
   import pwr_seq_pkg::*;
#(
   parameter int         XLIM_W     = 8,
   parameter logic [7:0] XLIM_RESET = XLIM_RST
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire bus_req_t    bus_req,
   output var  logic [7:0]  rdata,
   input  wire logic        wake_high_input,
   input  wire logic        pushbutton_wake_low_input,
   input  wire logic        supply_above_threshold,
   input  wire logic        osc_amplitude_ok,
   output var  logic        analog_supply_enable,
   output var  logic        digital_supply_enable,
   output var  logic        digital_supply_reset,
   output var  logic        digital_supply_good,
   output var  logic        irq,
   output var  logic        host_clock,
   output var  logic        base_tick,
   output var  logic        bitcheck_tick,
   output var  logic [2:0]  op_mode,
   output var  logic        rf_enable
);

   if (XLIM_W < 1 || XLIM_W > 8) begin : g_chk
      $error("power_mode_and_base_clock_control: XLIM_W out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // State of the whole block
   typedef struct packed {
      power_state_t      pstate;
      logic              supply_on;
      logic              sreset;
      logic              rst_flag;
      logic              pend_hi;
      logic              pend_bt;
      logic              st_hi;
      logic              st_bt;
      logic              irq;
      logic              dsg;
      logic [2:0]        mode;
      logic              rf_en;
      logic [XLIM_W-1:0] xlim;
      logic [1:0]        range;
      logic              clken;
      logic [1:0]        hcnt;
      logic              hgate;
      logic              hclk;
      logic [7:0]        rdata;
   } ctl_state_t;

   // The OFF state doubles as the register defaults
   localparam ctl_state_t Q_OFF = '{
      pstate : PWR_OFF,
      mode   : MODE_RST,
      xlim   : XLIM_W'(XLIM_RESET),
      range  : RANGE_RST,
      clken  : CLKEN_RST,
      default: '0
   };

   ctl_state_t q;
   ctl_state_t next_q;

   logic       wake_req;
   logic       pins_released;
   logic       bus_live;
   logic       clk_allowed;
   logic       base_run;
   logic       bc_run;
   logic [7:0] status_byte;
   logic [2:0] wr_mode;

   ////////////////////////////////////////////////////////////////////////
   // Helper decodes

   // Codes 4 and 6 are refused so the mode bits never hold them
   function automatic logic mode_code_used(input logic [2:0] code);
      return code != 3'h4 && code != 3'h6;
   endfunction : mode_code_used

   function automatic logic hit(input bus_req_t r, input logic [3:0] a);
      return r.addr == a;
   endfunction : hit

   // Wake pin levels
   assign wake_req      = wake_high_input || !pushbutton_wake_low_input;
   assign pins_released = !wake_high_input && pushbutton_wake_low_input;

   // Register port is dead while the rail is off or still in reset
   assign bus_live = q.pstate == PWR_IDLE && !q.sreset;

   // Host clock may start only with a good rail and a running oscillator
   assign clk_allowed = q.supply_on && q.dsg && osc_amplitude_ok
                        && q.clken;

   assign wr_mode = bus_req.wdata[MODE_LSB +: 3];

   // Status byte as software sees it
   always_comb begin
      status_byte                 = 8'h00;
      status_byte[ST_WAKE_HI_BIT] = q.st_hi;
      status_byte[ST_WAKE_BT_BIT] = q.st_bt;
      status_byte[ST_RST_BIT]     = q.rst_flag;
      status_byte[ST_DSG_BIT]     = q.dsg;
      status_byte[ST_OSC_BIT]     = osc_amplitude_ok;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_q       = q;
      next_q.rdata = 8'h00;

      // Rail monitor; nothing is good while the rail is switched off
      next_q.dsg = supply_above_threshold && q.supply_on;

      case (q.pstate)
         PWR_OFF: begin
            next_q     = Q_OFF;
            next_q.dsg = 1'b0;
            if (wake_req) begin
               next_q.pstate    = PWR_IDLE;
               next_q.supply_on = 1'b1;
               // Defaults loaded, reset flag raised
               next_q.sreset    = 1'b1;
               next_q.rst_flag  = 1'b1;
               // Remember which pin woke us until reset ends
               next_q.pend_hi   = wake_high_input;
               next_q.pend_bt   = !pushbutton_wake_low_input;
            end
         end

         PWR_IDLE: begin
            if (q.sreset) begin
               // Interrupt and wake bits stay quiet in reset
               next_q.irq   = 1'b0;
               next_q.st_hi = 1'b0;
               next_q.st_bt = 1'b0;
               if (q.dsg) begin
                  // Reset ends; the wake event is now reported
                  next_q.sreset = 1'b0;
                  next_q.irq    = 1'b1;
                  next_q.st_hi  = q.pend_hi;
                  next_q.st_bt  = q.pend_bt;
               end
            end else begin
               // Register reads; status read clears the event bits
               if (bus_req.rd) begin
                  if (hit(bus_req, ADDR_MODE)) begin
                     next_q.rdata[MODE_LSB +: 3] = q.mode;
                  end else if (hit(bus_req, ADDR_XLIM)) begin
                     next_q.rdata = 8'(q.xlim);
                  end else if (hit(bus_req, ADDR_RATE)) begin
                     next_q.rdata[RATE_RANGE_LSB +: 2] = q.range;
                     next_q.rdata[RATE_CLKEN_BIT]      = q.clken;
                  end else if (hit(bus_req, ADDR_STATUS)) begin
                     next_q.rdata = status_byte;
                     next_q.irq   = 1'b0;
                     next_q.st_hi = 1'b0;
                     next_q.st_bt = 1'b0;
                     // Flag survives a read until rail and oscillator are up
                     if (q.dsg && osc_amplitude_ok) begin
                        next_q.rst_flag = 1'b0;
                     end
                  end
               end

               // Register writes, accepted only in live IDLE
               if (bus_req.wr) begin
                  if (hit(bus_req, ADDR_MODE)) begin
                     if (mode_code_used(wr_mode)) begin
                        next_q.mode = wr_mode;
                     end
                  end else if (hit(bus_req, ADDR_XLIM)) begin
                     next_q.xlim = bus_req.wdata[XLIM_W-1:0];
                  end else if (hit(bus_req, ADDR_RATE)) begin
                     next_q.range = bus_req.wdata[RATE_RANGE_LSB +: 2];
                     next_q.clken = bus_req.wdata[RATE_CLKEN_BIT];
                  end
               end

               // OFF command or rail collapse end the active period, only with both wake pins released
               if (bus_req.wr && hit(bus_req, ADDR_CMD)
                   && bus_req.wdata[CMD_OFF_BIT] && pins_released) begin
                  next_q = Q_OFF;
               end else if (!q.dsg && pins_released) begin
                  next_q = Q_OFF;
               end
            end
         end

         default: begin
            next_q = Q_OFF;
         end
      endcase

      // RF section follows the mode bits; all-zero keeps it off
      next_q.rf_en = next_q.mode != OPM_IDLE;

      // Host clock: gate decided only at the wrap, so no runt pulses.
      // A single-edge design cannot give exactly 50 %: 2 high, 1 low.
      next_q.hcnt = (q.hcnt == 2'(HOST_DIV - 1)) ? 2'h0
                                                 : q.hcnt + 2'h1;
      next_q.hgate = (q.hcnt == 2'(HOST_DIV - 1)) ? clk_allowed
                                                  : q.hgate;
      next_q.hclk = next_q.hgate
                    && next_q.hcnt != 2'(HOST_DIV - 1);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         q <= Q_OFF;
      end else begin
         q <= next_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Base clock and bit-check timing
   assign base_run = q.supply_on && !q.sreset;
   assign bc_run   = base_run && q.mode != OPM_IDLE;

   // Base clock is a tick every 16 crystal cycles
   tick_divider #(
      .DIV (BASE_DIV)
   ) u_base_div (
      .mclk  (mclk),
      .reset (reset),
      .run   (base_run),
      .tick  (base_tick)
   );

   // Bit-check and TX bit clock from base ticks
   bitcheck_timer #(
      .XLIM_W (XLIM_W)
   ) u_bitcheck (
      .mclk      (mclk),
      .reset     (reset),
      .run       (bc_run),
      .base_tick (base_tick),
      .xlim      (q.xlim),
      .range     (q.range),
      .tick      (bitcheck_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all from the state register
   assign rdata                 = q.rdata;
   assign analog_supply_enable  = q.supply_on;
   assign digital_supply_enable = q.supply_on;
   assign digital_supply_reset  = q.sreset;
   assign digital_supply_good   = q.dsg;
   assign irq                   = q.irq;
   assign host_clock            = q.hclk;
   assign op_mode               = q.mode;
   assign rf_enable             = q.rf_en;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   // Base ticks are at least 9 cycles apart
   AST_BASE_SPACING:
   assert property (@(posedge mclk) disable iff (reset)
      base_tick |=> (!base_tick) [*8])
      else $error("base tick repeated too early");

   // Writes in OFF leave the mode bits alone
   AST_OFF_LOCKED:
   assert property (@(posedge mclk) disable iff (reset)
      (q.pstate == PWR_OFF && !wake_req && bus_req.wr)
      |=> op_mode == OPM_IDLE && q.pstate == PWR_OFF)
      else $error("register changed while off");

   // A wake pin moves OFF to IDLE under supply reset with flag set
   AST_WAKE_ENTERS_IDLE:
   assert property (@(posedge mclk) disable iff (reset)
      (q.pstate == PWR_OFF && wake_req)
      |=> q.pstate == PWR_IDLE && digital_supply_reset
          && q.rst_flag && digital_supply_enable)
      else $error("wake did not enter idle");

   // End of supply reset reports the wake source
   AST_WAKE_IRQ:
   assert property (@(posedge mclk) disable iff (reset)
      (q.sreset && q.dsg && q.pstate == PWR_IDLE)
      |=> irq && !digital_supply_reset
          && (q.st_hi == q.pend_hi) && (q.st_bt == q.pend_bt))
      else $error("wake not reported after reset");

   // Reset keeps the event outputs quiet
   AST_RESET_QUIET:
   assert property (@(posedge mclk) disable iff (reset)
      digital_supply_reset |-> !irq && !q.st_hi && !q.st_bt)
      else $error("event visible during supply reset");

   // Reset flag only falls after a status read with rail and oscillator up
   AST_RST_FLAG_CLEAR:
   assert property (@(posedge mclk) disable iff (reset)
      ($fell(q.rst_flag) && q.supply_on)
      |-> $past(bus_req.rd) && $past(bus_req.addr) == ADDR_STATUS
          && $past(q.dsg) && $past(osc_amplitude_ok))
      else $error("reset flag cleared without cause");

   // Three cycles of bad rail silence the host clock
   AST_HOST_CLK_GATED:
   assert property (@(posedge mclk) disable iff (reset)
      (!q.dsg) [*3] |=> !host_clock)
      else $error("host clock running without good rail");

   // Host clock shape: two cycles high, one low
   AST_HOST_CLK_SHAPE:
   assert property (@(posedge mclk) disable iff (reset)
      $rose(host_clock) |=> host_clock ##1 !host_clock)
      else $error("host clock shape wrong");

   // Rail loss with released pins falls back to OFF
   AST_FALLBACK:
   assert property (@(posedge mclk) disable iff (reset)
      (q.pstate == PWR_IDLE && !q.sreset && !q.dsg && pins_released)
      |=> q.pstate == PWR_OFF && !digital_supply_enable)
      else $error("no fallback on supply loss");

   // Unused mode codes are refused
   AST_UNUSED_MODE:
   assert property (@(posedge mclk) disable iff (reset)
      (bus_live && bus_req.wr && bus_req.addr == ADDR_MODE
       && !mode_code_used(wr_mode) && !(!q.dsg && pins_released))
      |=> $stable(op_mode))
      else $error("unused mode code accepted");

   // All-zero mode keeps RF off; any other keeps it on
   AST_RF_FOLLOWS_MODE:
   assert property (@(posedge mclk) disable iff (reset)
      rf_enable == (op_mode != OPM_IDLE))
      else $error("rf enable disagrees with mode");

endmodule : power_mode_and_base_clock_control
`default_nettype wire

//--- pwr_seq_pkg.sv
// Shared constants and carrier types of the power-mode sequencer.
// Assumes one crystal-rate clock and a plain strobe register port.
package pwr_seq_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Clock dividers
   localparam int BASE_DIV = 16;           // Crystal to base clock
   localparam int HOST_DIV = 3;            // Crystal to host clock

   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [3:0] ADDR_MODE   = 4'h0;
   localparam logic [3:0] ADDR_XLIM   = 4'h1;
   localparam logic [3:0] ADDR_RATE   = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_CMD    = 4'h4;

   // Field positions
   localparam int MODE_LSB       = 1;      // Mode code in bits 3:1
   localparam int RATE_RANGE_LSB = 0;      // Range in bits 1:0
   localparam int RATE_CLKEN_BIT = 2;
   localparam int ST_WAKE_HI_BIT = 0;
   localparam int ST_WAKE_BT_BIT = 1;
   localparam int ST_RST_BIT     = 2;
   localparam int ST_DSG_BIT     = 3;
   localparam int ST_OSC_BIT     = 4;
   localparam int CMD_OFF_BIT    = 0;

   // Reset values
   localparam logic [2:0] MODE_RST  = 3'h0;
   localparam logic [7:0] XLIM_RST  = 8'h10;
   localparam logic [1:0] RANGE_RST = 2'h0;
   localparam logic       CLKEN_RST = 1'b1;

   // Operating-mode codes
   localparam logic [2:0] OPM_IDLE = 3'h0;
   localparam logic [2:0] OPM_TX   = 3'h1;
   localparam logic [2:0] OPM_POLL = 3'h2;
   localparam logic [2:0] OPM_RX   = 3'h3;
   localparam logic [2:0] OPM_FDM  = 3'h5;
   localparam logic [2:0] OPM_FDS  = 3'h7;

   typedef enum logic [0:0] {PWR_OFF, PWR_IDLE} power_state_t;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;

endpackage : pwr_seq_pkg

//--- tick_divider.sv
// Fixed divider giving a one-cycle tick every DIV clocks while run is high.
// Assumes run is a registered level of the caller.
`timescale 1ns/1ps
`default_nettype none
module tick_divider
   import pwr_seq_pkg::*;
#(
   parameter int DIV = BASE_DIV
) (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic run,
   output var  logic tick
);

   if (DIV < 2 || DIV > 256) begin : g_chk
      $error("tick_divider: DIV out of range");
   end

   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } div_state_t;

   div_state_t q;
   div_state_t next_q;

   // Counter restarts when run drops so the first tick is a full period
   always_comb begin
      next_q      = q;
      next_q.tick = 1'b0;
      if (!run) begin
         next_q.cnt = 8'h00;
      end else if (q.cnt == 8'(DIV - 1)) begin
         next_q.cnt  = 8'h00;
         next_q.tick = 1'b1;
      end else begin
         next_q.cnt = q.cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign tick = q.tick;

endmodule : tick_divider
`default_nettype wire

//--- bitcheck_timer.sv
// Bit-check and transmit bit timer counted in base-clock ticks.
// Assumes base_tick is a one-cycle pulse from the base divider.
`timescale 1ns/1ps
`default_nettype none
module bitcheck_timer
   import pwr_seq_pkg::*;
#(
   parameter int XLIM_W = 8
) (
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire logic              run,
   input  wire logic              base_tick,
   input  wire logic [XLIM_W-1:0] xlim,
   input  wire logic [1:0]        range,
   output var  logic              tick
);

   if (XLIM_W < 1 || XLIM_W > 8) begin : g_chk
      $error("bitcheck_timer: XLIM_W out of range");
   end

   typedef struct packed {
      logic [XLIM_W+2:0] cnt;
      logic              tick;
   } bc_state_t;

   bc_state_t q;
   bc_state_t next_q;

   // Period in base ticks: limit times 8, 4, 2 or 1; a zero limit acts as 1
   function automatic logic [XLIM_W+2:0] period_of(
      input logic [XLIM_W-1:0] lim,
      input logic [1:0]        rng
   );
      logic [XLIM_W+2:0] full;
      full = {((lim == '0) ? XLIM_W'(1) : lim), 3'b000};
      return full >> rng;
   endfunction : period_of

   // One tick per period, timed only on base ticks
   always_comb begin
      next_q      = q;
      next_q.tick = 1'b0;
      if (!run) begin
         next_q.cnt = '0;
      end else if (base_tick) begin
         if (q.cnt >= period_of(xlim, range) - 1'b1) begin
            next_q.cnt  = '0;
            next_q.tick = 1'b1;
         end else begin
            next_q.cnt = q.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign tick = q.tick;

endmodule : bitcheck_timer
`default_nettype wire

//--- host_model.sv
// Host controller model: register port master and the two wake pins.
// Assumes the device samples strobes on the rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module host_model
   import pwr_seq_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic [7:0] rdata,
   output var  bus_req_t   bus_req,
   output var  logic       wake_high_input,
   output var  logic       pushbutton_wake_low_input
);
   // Idle pins: released wake lines, no strobe
   initial begin
      bus_req = '{addr: 4'h5, wdata: 8'h5a, wr: 1'b0, rd: 1'b0};
      wake_high_input = 1'b0;
      pushbutton_wake_low_input = 1'b1;
   end

   ////////////////////////////////////////
   // One strobe cycle; address and data scrambled once released
   task automatic xfer(input logic w, input logic [3:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge mclk);
      bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
      #1 q = rdata;
   endtask : xfer

   // Short press only, the pull-up burns current while low
   task automatic press;
      @(posedge mclk);
      pushbutton_wake_low_input <= 1'b0;
      repeat (2) @(posedge mclk);
      pushbutton_wake_low_input <= 1'b1;
      #1;
   endtask : press

   task automatic set_high(input logic v);
      @(posedge mclk);
      wake_high_input <= v;
   endtask : set_high

   // Pins released before the off command goes out
   task automatic off_cmd;
      logic [7:0] q;
      set_high(1'b0);
      pushbutton_wake_low_input <= 1'b1;
      xfer(1'b1, ADDR_CMD, 8'h01, q);
   endtask : off_cmd
endmodule : host_model
`default_nettype wire

//--- power_mode_and_base_clock_control_tb.sv
// Self-checking bench of the power-mode sequencer.
// Assumes host_model drives the register port and wake pins.
`timescale 1ns/1ps
`default_nettype none
module power_mode_and_base_clock_control_tb;
   import pwr_seq_pkg::*;
   logic       mclk, reset, supply_above_threshold, osc_amplitude_ok;
   bus_req_t   bus_req;
   logic [7:0] rdata, q;
   logic       wake_high_input, pushbutton_wake_low_input, irq;
   logic       analog_supply_enable, digital_supply_enable;
   logic       digital_supply_reset, digital_supply_good, rf_enable;
   logic       host_clock, base_tick, bitcheck_tick;
   logic [2:0] op_mode, cur;
   int         error_cnt, num_checks, n;
   wire  [2:0] mon = {host_clock, bitcheck_tick, base_tick};

   power_mode_and_base_clock_control dut (.mclk, .reset, .bus_req,
      .rdata, .wake_high_input, .pushbutton_wake_low_input,
      .supply_above_threshold, .osc_amplitude_ok, .analog_supply_enable,
      .digital_supply_enable, .digital_supply_reset, .digital_supply_good,
      .irq, .host_clock, .base_tick, .bitcheck_tick, .op_mode, .rf_enable);
   host_model host (.mclk, .rdata, .bus_req, .wake_high_input,
      .pushbutton_wake_low_input);

   ////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out

   // Cycles from one rise of a monitored output to the next
   task automatic period(input int sel, output int cnt);
      cnt = 0;
      for (int ph = 0; ph < 4; ph++) begin
         do begin
            @(posedge mclk);
            #1;
            if (ph > 1) cnt++;
         end while (mon[sel] !== ph[0]);
      end
   endtask : period

   // Rail comes up; bounded wait for the supply reset to drop
   task automatic power_up(input logic osc);
      @(posedge mclk);
      supply_above_threshold <= 1'b1;
      osc_amplitude_ok <= osc;
      repeat (20) begin
         @(posedge mclk);
         #1;
         if (digital_supply_reset === 1'b0) break;
      end
   endtask : power_up

   // Hang guard, far beyond the expected run
   initial begin
      #1000000;
      error_cnt++;
      close_out();
   end

   ////////////////////////////////////////
   initial begin
      error_cnt = 0;
      num_checks = 0;
      reset = 1'b1;
      supply_above_threshold = 1'b0;
      osc_amplitude_ok = 1'b0;
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      // Off: writes and reads have no effect
      host.xfer(1'b1, ADDR_MODE, 8'h02, q);
      host.xfer(1'b0, ADDR_STATUS, 8'h00, q);
      check(q, 8'h00);
      check({5'h0, op_mode}, 8'h00);
      // Push-button wake, interrupt held off under supply reset
      host.press();
      check({5'h0, irq, analog_supply_enable, digital_supply_reset},
            8'h03);
      power_up(1'b1);
      check({6'h0, irq, digital_supply_good}, 8'h03);
      host.xfer(1'b0, ADDR_STATUS, 8'h00, q);
      check(q, 8'h1e);
      check({7'h0, irq}, 8'h00);
      host.xfer(1'b0, ADDR_STATUS, 8'h00, q);
      check(q, 8'h18);
      host.xfer(1'b0, ADDR_XLIM, 8'h00, q);
      check(q, 8'h10);
      host.xfer(1'b0, ADDR_RATE, 8'h00, q);
      check(q, 8'h04);
      period(0, n);
      check(n[7:0], 8'h10);
      period(2, n);
      check(n[7:0], 8'h03);
      // Every mode code; unused codes leave the mode alone
      cur = OPM_IDLE;
      for (int m = 0; m < 8; m++) begin
         host.xfer(1'b1, ADDR_MODE, {4'h0, m[2:0], 1'b0}, q);
         if (m != 4 && m != 6) cur = m[2:0];
         check({4'h0, rf_enable, op_mode},
               {4'h0, cur != 3'h0, cur});
      end
      // Bit-check period over all four ranges, limit 1
      host.xfer(1'b1, ADDR_XLIM, 8'h01, q);
      for (int r = 0; r < 4; r++) begin
         host.xfer(1'b1, ADDR_RATE, {6'h01, r[1:0]}, q);
         period(1, n);
         check(n[7:0], 8'h80 >> r);
      end
      // Rail loss with pins released drops back to off
      @(posedge mclk);
      supply_above_threshold <= 1'b0;
      repeat (4) @(posedge mclk);
      #1 check({7'h0, analog_supply_enable}, 8'h00);
      // High-pin wake; flag kept while oscillator not ready
      host.set_high(1'b1);
      power_up(1'b0);
      host.xfer(1'b0, ADDR_STATUS, 8'h00, q);
      check(q, 8'h0d);
      host.xfer(1'b0, ADDR_STATUS, 8'h00, q);
      check(q, 8'h0c);
      check({7'h0, host_clock}, 8'h00);
      @(posedge mclk);
      osc_amplitude_ok <= 1'b1;
      host.xfer(1'b0, ADDR_STATUS, 8'h00, q);
      check(q, 8'h1c);
      host.xfer(1'b0, ADDR_STATUS, 8'h00, q);
      check(q, 8'h18);
      // Off command refused while the wake pin is held
      host.xfer(1'b1, ADDR_CMD, 8'h01, q);
      check({7'h0, analog_supply_enable}, 8'h01);
      host.off_cmd();
      check({6'h0, analog_supply_enable, digital_supply_enable},
            8'h00);
      close_out();
   end
endmodule : power_mode_and_base_clock_control_tb
`default_nettype wire
